// ===== src/dbg_cmd_pkg.sv
// Package of constants and types shared by the serial debug command unit.
package dbg_cmd_pkg;

  // ****************************************************************
  // Internal register select codes
  // ****************************************************************
  localparam logic [3:0] SEL_HOLD_N0  = 4'h0;
  localparam logic [3:0] SEL_HOLD_N3  = 4'h3;
  localparam logic [3:0] SEL_ADDR_N0  = 4'h4;
  localparam logic [3:0] SEL_ADDR_N3  = 4'h7;
  localparam logic [3:0] SEL_COMMAND  = 4'h8;
  localparam logic [3:0] SEL_MODE     = 4'h9;

  // ****************************************************************
  // Command codes
  // ****************************************************************
  localparam logic [3:0] CMD_PORT_WR   = 4'h0;
  localparam logic [3:0] CMD_FLASH_WR  = 4'h1;
  localparam logic [3:0] CMD_PORT_RD   = 4'h2;
  localparam logic [3:0] CMD_FLASH_RD  = 4'h3;
  localparam logic [3:0] CMD_ACC_RD    = 4'h4;
  localparam logic [3:0] CMD_PCMEM_RD  = 4'h5;
  localparam logic [3:0] CMD_PC_RD     = 4'h6;
  localparam logic [3:0] CMD_HALT      = 4'h7;
  localparam logic [3:0] CMD_START     = 4'h8;
  localparam logic [3:0] CMD_STEP      = 4'h9;
  localparam logic [3:0] CMD_PC_ZERO   = 4'hA;
  localparam logic [3:0] CMD_MOD_RESET = 4'hB;
  localparam logic [3:0] CMD_NOP       = 4'hC;
  localparam logic [3:0] CMD_PAGE_ERASE = 4'hD;
  localparam logic [3:0] CMD_PART_ERASE = 4'hE;
  localparam logic [3:0] CMD_AUX_SEL   = 4'hF;

  // ****************************************************************
  // Interface modes, field positions and reset values
  // ****************************************************************
  localparam logic [3:0]  MODE_FOUR_WIRE  = 4'h0;
  localparam logic [3:0]  MODE_THREE_WIRE = 4'h1;
  localparam int          FLASH_ADDR_MSB  = 11;
  localparam int          PAGE_LSB        = 6;
  localparam logic [15:0] HOLD_RESET      = 16'h0000;
  localparam logic [15:0] ADDR_RESET      = 16'h0000;
  localparam logic [3:0]  CMD_RESET       = 4'hC;
  localparam logic [3:0]  MODE_RESET      = 4'h0;

  typedef enum logic [2:0] {ST_IDLE, ST_PORT_WAIT, ST_FLASH_WAIT, ST_STEP} exec_state_t;

endpackage : dbg_cmd_pkg

// ===== src/nibble_write_decoder.sv
// Nibble write decoder that steers one data nibble into the internal registers.
`timescale 1ns/1ps
module nibble_write_decoder (
  input  wire logic        mclk_in,       // System clock.
  input  wire logic        rst_n_in,      // Asynchronous reset, active low.
  input  wire logic        clk_en_in,     // Clock enable.
  input  wire logic        wr_in,         // One-cycle nibble write strobe.
  input  wire logic [3:0]  sel_in,        // Internal select address.
  input  wire logic [3:0]  nibble_in,     // Nibble to write.
  input  wire logic        hold_ld_in,    // Command load of the holding register.
  input  wire logic [15:0] hold_val_in,   // Value for the command load.
  input  wire logic        hold_lo_in,    // Command load touches the low byte only.
  output logic      [15:0] hold_out,      // Data holding register.
  output logic      [15:0] addr_out,      // Port and flash address register.
  output logic      [3:0]  cmd_out,       // Command register.
  output logic      [3:0]  mode_out,      // Interface mode register.
  output logic             cmd_go_out     // Pulse after a command write.
);

  // ****************************************************************
  // Holding and address nibbles
  // ****************************************************************
  genvar n;
  generate
    for (n = 0; n < 4; n++) begin : g_nib
      always_ff @(posedge mclk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
          hold_out[4*n +: 4] <= dbg_cmd_pkg::HOLD_RESET[4*n +: 4];
          addr_out[4*n +: 4] <= dbg_cmd_pkg::ADDR_RESET[4*n +: 4];
        end else if (clk_en_in) begin
          if (hold_ld_in && (!hold_lo_in || n < 2)) begin
            hold_out[4*n +: 4] <= hold_val_in[4*n +: 4];
          end else if (wr_in && sel_in == 4'(dbg_cmd_pkg::SEL_HOLD_N0 + n)) begin
            hold_out[4*n +: 4] <= nibble_in;
          end
          if (wr_in && sel_in == 4'(dbg_cmd_pkg::SEL_ADDR_N0 + n)) begin
            addr_out[4*n +: 4] <= nibble_in;
          end
        end
      end
    end
  endgenerate

  // ****************************************************************
  // Command and mode registers
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cmd_out    <= dbg_cmd_pkg::CMD_RESET;
      mode_out   <= dbg_cmd_pkg::MODE_RESET;
      cmd_go_out <= 1'b0;
    end else if (clk_en_in) begin
      cmd_go_out <= wr_in && sel_in == dbg_cmd_pkg::SEL_COMMAND;
      if (wr_in && sel_in == dbg_cmd_pkg::SEL_COMMAND) begin
        cmd_out <= nibble_in;
      end
      // Codes above the mode select fall through and change nothing.
      if (wr_in && sel_in == dbg_cmd_pkg::SEL_MODE) begin
        mode_out <= nibble_in;
      end
    end
  end

endmodule : nibble_write_decoder

// ===== src/serial_debug_command_unit.sv
// Command unit that runs debug commands against the CPU core and flash controller.
`timescale 1ns/1ps
module serial_debug_command_unit (
  input  wire logic        mclk_in,             // System clock, 200 MHz.
  input  wire logic        rst_n_in,            // Asynchronous reset, active low.
  input  wire logic        clk_en_in,           // Clock enable; low freezes all state.
  input  wire logic        nibble_wr_in,        // One-cycle nibble write from the framer.
  input  wire logic [3:0]  internal_select_address_in,  // Internal register select.
  input  wire logic [3:0]  internal_select_nibble_in,   // Nibble data to write.
  input  wire logic        flash_write_power_enable_in, // Flash write enable bit, level.
  input  wire logic        cpu_port_busy_in,    // CPU uses the ports this cycle.
  input  wire logic [15:0] port_rdata_in,       // Data of the addressed port.
  input  wire logic [15:0] acc_in,              // CPU accumulator.
  input  wire logic [15:0] program_counter_in,  // CPU program counter.
  input  wire logic        flash_done_in,       // Flash controller finished.
  input  wire logic [7:0]  flash_rdata_in,      // Flash read byte.
  output logic      [15:0] data_holding_out,    // Holding register, readable by host.
  output logic      [3:0]  port_sel_out,        // Port index.
  output logic      [15:0] port_wdata_out,      // Port write data.
  output logic             port_wr_out,         // Port write pulse.
  output logic             cpu_halt_out,        // CPU halted level.
  output logic             cpu_step_out,        // One-cycle CPU enable while halted.
  output logic             pc_clear_out,        // Program counter clear pulse.
  output logic             module_reset_out,    // Peripheral, flash and D/E/F reset pulse.
  output logic             flash_req_out,       // Flash request pulse.
  output logic      [1:0]  flash_op_out,        // 0 read, 1 write, 2 page erase, 3 part erase.
  output logic      [11:0] flash_addr_out,      // Flash byte address.
  output logic      [7:0]  flash_wdata_out,     // Flash write byte.
  output logic             aux_flash_partition_out, // High selects the auxiliary partition.
  output logic             three_wire_out       // High for three-wire serial mode.
);

  // ****************************************************************
  // Internal registers
  // ****************************************************************
  logic [15:0] hold;
  logic [15:0] addr;
  logic [3:0]  cmd;
  logic [3:0]  mode;
  logic        cmd_go;
  logic        hold_ld;
  logic [15:0] hold_val;
  logic        hold_lo;
  logic        fl_pc;
  dbg_cmd_pkg::exec_state_t state;

  nibble_write_decoder u_dec (
    .mclk_in     (mclk_in),
    .rst_n_in    (rst_n_in),
    .clk_en_in   (clk_en_in),
    .wr_in       (nibble_wr_in),
    .sel_in      (internal_select_address_in),
    .nibble_in   (internal_select_nibble_in),
    .hold_ld_in  (hold_ld),
    .hold_val_in (hold_val),
    .hold_lo_in  (hold_lo),
    .hold_out    (hold),
    .addr_out    (addr),
    .cmd_out     (cmd),
    .mode_out    (mode),
    .cmd_go_out  (cmd_go)
  );

  // ****************************************************************
  // Command execution
  // ****************************************************************
  // Port commands wait while the CPU owns the ports, since the CPU wins any clash.
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state            <= dbg_cmd_pkg::ST_IDLE;
      cpu_halt_out     <= 1'b0;
      cpu_step_out     <= 1'b0;
      pc_clear_out     <= 1'b0;
      module_reset_out <= 1'b0;
      port_wr_out      <= 1'b0;
      flash_req_out    <= 1'b0;
      flash_op_out     <= 2'h0;
      aux_flash_partition_out <= 1'b0;
      hold_ld          <= 1'b0;
      hold_val         <= 16'h0000;
      hold_lo          <= 1'b0;
      fl_pc            <= 1'b0;
    end else if (clk_en_in) begin
      cpu_step_out     <= 1'b0;
      pc_clear_out     <= 1'b0;
      module_reset_out <= 1'b0;
      port_wr_out      <= 1'b0;
      flash_req_out    <= 1'b0;
      hold_ld          <= 1'b0;
      case (state)
        dbg_cmd_pkg::ST_IDLE: begin
          if (cmd_go) begin
            case (cmd)
              dbg_cmd_pkg::CMD_PORT_WR, dbg_cmd_pkg::CMD_PORT_RD:
                state <= dbg_cmd_pkg::ST_PORT_WAIT;
              dbg_cmd_pkg::CMD_FLASH_WR: begin
                if (flash_write_power_enable_in) begin
                  flash_req_out <= 1'b1;
                  flash_op_out  <= 2'h1;
                  fl_pc         <= 1'b0;
                  state         <= dbg_cmd_pkg::ST_FLASH_WAIT;
                end
              end
              dbg_cmd_pkg::CMD_FLASH_RD, dbg_cmd_pkg::CMD_PCMEM_RD: begin
                if (cpu_halt_out) begin
                  flash_req_out <= 1'b1;
                  flash_op_out  <= 2'h0;
                  fl_pc         <= cmd == dbg_cmd_pkg::CMD_PCMEM_RD;
                  state         <= dbg_cmd_pkg::ST_FLASH_WAIT;
                end
              end
              dbg_cmd_pkg::CMD_ACC_RD: begin
                hold_ld  <= cpu_halt_out;
                hold_val <= acc_in;
                hold_lo  <= 1'b0;
              end
              dbg_cmd_pkg::CMD_PC_RD: begin
                hold_ld  <= cpu_halt_out;
                hold_val <= program_counter_in;
                hold_lo  <= 1'b0;
              end
              dbg_cmd_pkg::CMD_HALT: begin
                cpu_halt_out            <= 1'b1;
                aux_flash_partition_out <= 1'b0;
              end
              dbg_cmd_pkg::CMD_START: begin
                if (cpu_halt_out) cpu_halt_out <= 1'b0;
              end
              dbg_cmd_pkg::CMD_STEP: begin
                if (cpu_halt_out) begin
                  cpu_step_out <= 1'b1;
                  state        <= dbg_cmd_pkg::ST_STEP;
                end
              end
              dbg_cmd_pkg::CMD_PC_ZERO: pc_clear_out <= cpu_halt_out;
              dbg_cmd_pkg::CMD_MOD_RESET: module_reset_out <= cpu_halt_out;
              dbg_cmd_pkg::CMD_PAGE_ERASE, dbg_cmd_pkg::CMD_PART_ERASE: begin
                if (cpu_halt_out) begin
                  flash_req_out <= 1'b1;
                  flash_op_out  <= (cmd == dbg_cmd_pkg::CMD_PAGE_ERASE) ? 2'h2 : 2'h3;
                  fl_pc         <= 1'b0;
                  state         <= dbg_cmd_pkg::ST_FLASH_WAIT;
                end
              end
              dbg_cmd_pkg::CMD_AUX_SEL: aux_flash_partition_out <= 1'b1;
              default: ;
            endcase
          end
        end
        dbg_cmd_pkg::ST_PORT_WAIT: begin
          if (!cpu_port_busy_in) begin
            if (cmd == dbg_cmd_pkg::CMD_PORT_WR) begin
              port_wr_out <= 1'b1;
            end else begin
              hold_ld  <= 1'b1;
              hold_val <= port_rdata_in;
              hold_lo  <= 1'b0;
            end
            state <= dbg_cmd_pkg::ST_IDLE;
          end
        end
        dbg_cmd_pkg::ST_FLASH_WAIT: begin
          if (flash_done_in) begin
            if (flash_op_out == 2'h0) begin
              hold_ld  <= 1'b1;
              hold_val <= {8'h00, flash_rdata_in};
              hold_lo  <= 1'b1;
            end
            state <= dbg_cmd_pkg::ST_IDLE;
          end
        end
        dbg_cmd_pkg::ST_STEP: state <= dbg_cmd_pkg::ST_IDLE;
        default: state <= dbg_cmd_pkg::ST_IDLE;
      endcase
    end
  end

  // ****************************************************************
  // Registered outputs
  // ****************************************************************
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      data_holding_out <= dbg_cmd_pkg::HOLD_RESET;
      port_sel_out     <= 4'h0;
      port_wdata_out   <= 16'h0000;
      flash_addr_out   <= 12'h000;
      flash_wdata_out  <= 8'h00;
      three_wire_out   <= 1'b0;
    end else if (clk_en_in) begin
      data_holding_out <= hold;
      port_sel_out     <= addr[3:0];
      port_wdata_out   <= hold;
      flash_wdata_out  <= hold[7:0];
      if (fl_pc) begin
        flash_addr_out <= program_counter_in[dbg_cmd_pkg::FLASH_ADDR_MSB:0];
      end else if (flash_op_out == 2'h2) begin
        flash_addr_out <= {addr[dbg_cmd_pkg::FLASH_ADDR_MSB:dbg_cmd_pkg::PAGE_LSB],
                           6'h00};
      end else begin
        flash_addr_out <= addr[dbg_cmd_pkg::FLASH_ADDR_MSB:0];
      end
      // Unused mode codes keep the four-wire pinout, the safe default.
      three_wire_out <= (mode == dbg_cmd_pkg::MODE_THREE_WIRE);
    end
  end

endmodule : serial_debug_command_unit

// ===== test/serial_debug_command_unit_assertions.sv
// Checker of the serial debug command unit seen from its ports.
`timescale 1ns/1ps
module serial_debug_command_unit_assertions (
  input wire logic        mclk_in,                  // Clock.
  input wire logic        rst_n_in,                 // Reset, active low.
  input wire logic        nibble_wr_in,             // Nibble write strobe.
  input wire logic [3:0]  internal_select_address_in,  // Register select.
  input wire logic [3:0]  internal_select_nibble_in,   // Nibble data.
  input wire logic        flash_write_power_enable_in, // Flash write enable.
  input wire logic        cpu_port_busy_in,         // CPU on the ports.
  input wire logic [15:0] data_holding_out,         // Holding register.
  input wire logic        port_wr_out,              // Port write pulse.
  input wire logic        cpu_halt_out,             // Halt level.
  input wire logic        cpu_step_out,             // Step pulse.
  input wire logic        pc_clear_out,             // Counter clear pulse.
  input wire logic        flash_req_out,            // Flash request.
  input wire logic        aux_flash_partition_out,     // Auxiliary partition.
  input wire logic        three_wire_out            // Three-wire mode.
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  wire cmd_wr = nibble_wr_in && internal_select_address_in == 4'h8;
  chk_hold_nibble: assert property (nibble_wr_in && internal_select_address_in == 4'h0
    |-> ##2 data_holding_out[3:0] == $past(internal_select_nibble_in, 2))
    else $error("holding nibble not loaded");
  chk_halt_main: assert property (cmd_wr && internal_select_nibble_in == 4'h7
    |-> ##2 cpu_halt_out && !aux_flash_partition_out) else $error("halt failed");
  chk_start_run: assert property (cmd_wr && internal_select_nibble_in == 4'h8
    && cpu_halt_out |-> ##2 !cpu_halt_out) else $error("start failed");
  chk_step_once: assert property (cpu_step_out |-> cpu_halt_out ##1 !cpu_step_out)
    else $error("step not single");
  chk_pc_halted: assert property (pc_clear_out |-> cpu_halt_out)
    else $error("counter cleared while running");
  chk_flash_gate: assert property (!flash_write_power_enable_in [*3] ##0 !cpu_halt_out
    |-> !flash_req_out) else $error("flash request without enable");
  chk_port_prio: assert property (port_wr_out |-> $past(!cpu_port_busy_in))
    else $error("port write beat the CPU");
  chk_mode_three: assert property (nibble_wr_in && internal_select_address_in == 4'h9
    && internal_select_nibble_in == 4'h1 |-> ##[1:2] three_wire_out)
    else $error("three-wire mode not set");
  cover property (cpu_step_out);
  cover property (port_wr_out);
  cover property (flash_req_out && cpu_halt_out);
endmodule : serial_debug_command_unit_assertions
bind serial_debug_command_unit serial_debug_command_unit_assertions i_chk (.mclk_in,
  .rst_n_in, .nibble_wr_in, .internal_select_address_in, .internal_select_nibble_in,
  .flash_write_power_enable_in, .cpu_port_busy_in, .data_holding_out, .port_wr_out,
  .cpu_halt_out, .cpu_step_out, .pc_clear_out, .flash_req_out, .aux_flash_partition_out,
  .three_wire_out);

// ===== test/cpu_flash_model.sv
// Behavioural model of the CPU core and flash controller.
`timescale 1ns/1ps
module cpu_flash_model #(
  parameter logic [15:0] ACC_VALUE = 16'h4E21
) (
  input  wire logic        mclk_in,     // Clock.
  input  wire logic        rst_n_in,    // Reset, active low.
  input  wire logic        req_in,      // Flash request pulse.
  input  wire logic        halt_in,     // CPU halted.
  input  wire logic        step_in,     // Single step.
  input  wire logic        clear_in,    // Counter clear.
  input  wire logic [11:0] addr_in,     // Flash address.
  input  wire logic [3:0]  sel_in,      // Port index.
  output logic             done_out,    // Flash done pulse.
  output logic      [7:0]  rdata_out,   // Flash read byte.
  output logic      [15:0] pc_out,      // Program counter.
  output logic      [15:0] port_out,    // Port read data.
  output logic      [15:0] acc_out      // Accumulator.
);
  logic [1:0] cnt;
  assign acc_out = ACC_VALUE;
  assign port_out = {12'hC0D, sel_in};
  // Outside the done cycle the byte is inverted so a late sample shows up.
  assign rdata_out = done_out ? addr_in[7:0] ^ 8'h5A : ~(addr_in[7:0] ^ 8'h5A);
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pc_out <= 16'h0000;
    end else if (clear_in) begin
      pc_out <= 16'h0000;
    end else if (!halt_in || step_in) begin
      pc_out <= pc_out + 16'h0001;
    end
  end
  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cnt <= 2'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= cnt == 2'h1;
      cnt <= req_in ? 2'h3 : (cnt != 2'h0 ? cnt - 2'h1 : 2'h0);
    end
  end
endmodule : cpu_flash_model

// ===== test/tb_serial_debug_command_unit.sv
// Testbench of the serial debug command unit.
`timescale 1ns/1ps
module tb_serial_debug_command_unit;
  logic clk = 0, rst_n = 0, wr = 0, pwr = 1, busy = 0, fdone, fstep, fclr, preq, halt;
  logic mrst, pwr_s, aux, tw;
  logic [3:0] sel = 4'h0, nib = 4'h0, psel;
  logic [15:0] hold, prd, acc, pc, pwd, cap_pw;
  logic [1:0] fop, cap_op;
  logic [11:0] fadr, cap_adr;
  logic [7:0] frd, fwd, cap_wd;
  logic [3:0] cap_ps;
  int fails = 0, compares = 0, cyc = 0, n_pw = 0, n_fr = 0, n_pc = 0, n_mr = 0, n_st = 0;
  always #2.5 clk = ~clk;
  serial_debug_command_unit i_dut (.mclk_in(clk), .rst_n_in(rst_n), .clk_en_in(1'b1),
    .nibble_wr_in(wr), .internal_select_address_in(sel), .internal_select_nibble_in(nib),
    .flash_write_power_enable_in(pwr), .cpu_port_busy_in(busy), .port_rdata_in(prd),
    .acc_in(acc), .program_counter_in(pc), .flash_done_in(fdone), .flash_rdata_in(frd),
    .data_holding_out(hold), .port_sel_out(psel), .port_wdata_out(pwd), .port_wr_out(pwr_s),
    .cpu_halt_out(halt), .cpu_step_out(fstep), .pc_clear_out(fclr), .module_reset_out(mrst),
    .flash_req_out(preq), .flash_op_out(fop), .flash_addr_out(fadr),
    .flash_wdata_out(fwd), .aux_flash_partition_out(aux), .three_wire_out(tw));
  cpu_flash_model i_cpu (.mclk_in(clk), .rst_n_in(rst_n), .req_in(preq), .halt_in(halt),
    .step_in(fstep), .clear_in(fclr), .addr_in(fadr), .sel_in(psel), .done_out(fdone),
    .rdata_out(frd), .pc_out(pc), .port_out(prd), .acc_out(acc));
  always @(posedge clk) begin
    n_pw += pwr_s; n_fr += preq; n_pc += fclr; n_mr += mrst; n_st += fstep;
    if (pwr_s) begin cap_pw = pwd; cap_ps = psel; end
    if (fdone) begin cap_op = fop; cap_adr = fadr; cap_wd = fwd; end
    if (++cyc == 5000) begin fails++; close_out(); end
  end
  task automatic close_out();
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : close_out
  task automatic chk(string n, logic [15:0] e, logic [15:0] g);
    compares++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  task automatic put(logic [3:0] s, logic [3:0] v);
    @(posedge clk) begin wr <= 1; sel <= s; nib <= v; end
    @(posedge clk) wr <= 0;
  endtask : put
  task automatic put16(logic [3:0] b, logic [15:0] v);
    for (int i = 0; i < 4; i++) put(b + 4'(i), v[4*i +: 4]);
  endtask : put16
  task automatic cmd(logic [3:0] c);
    put(4'h8, c);
    repeat (12) @(posedge clk);
  endtask : cmd
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1;
    chk("halt", 16'h0, 16'(halt));
    put16(4'h0, 16'hA5C3);
    for (int s = 10; s < 16; s++) put(4'(s), 4'hF);
    repeat (2) @(posedge clk);
    chk("hold", 16'hA5C3, hold);
    put(4'h9, 4'h1); repeat (3) @(posedge clk); chk("mode", 16'h1, 16'(tw));
    put(4'h9, 4'h0); repeat (3) @(posedge clk); chk("mode", 16'h0, 16'(tw));
    put16(4'h4, 16'h0ABC);
    cmd(4'h0); chk("pw", 16'hA5C3, cap_pw); chk("ps", 16'hC, 16'(cap_ps));
    busy <= 1; cmd(4'h2); chk("hold", 16'hA5C3, hold);
    busy <= 0; repeat (12) @(posedge clk); chk("hold", 16'hC0DC, hold);
    chk("npw", 16'h1, 16'(n_pw));
    pwr <= 0; cmd(4'h1); chk("nfr", 16'h0, 16'(n_fr));
    pwr <= 1; cmd(4'h1); chk("op", 16'h1, 16'(cap_op)); chk("wd", 16'hDC, 16'(cap_wd));
    chk("adr", 16'hABC, 16'(cap_adr));
    cmd(4'hA); cmd(4'h4); chk("npc", 16'h0, 16'(n_pc)); chk("hold", 16'hC0DC, hold);
    cmd(4'h7); chk("halt", 16'h1, 16'(halt));
    cmd(4'h4); chk("hold", 16'h4E21, hold);
    cmd(4'hA); cmd(4'h9); cmd(4'h6); chk("nst", 16'h1, 16'(n_st));
    chk("hold", 16'h0001, hold);
    cmd(4'h5); chk("hold", 16'h005B, hold);
    cmd(4'h3); chk("hold", 16'h00E6, hold);
    cmd(4'hD); chk("op", 16'h2, 16'(cap_op)); chk("adr", 16'hA80, 16'(cap_adr));
    cmd(4'hF); chk("aux", 16'h1, 16'(aux));
    cmd(4'hE); chk("op", 16'h3, 16'(cap_op)); chk("aux", 16'h1, 16'(aux));
    cmd(4'h7); chk("aux", 16'h0, 16'(aux));
    cmd(4'hB); cmd(4'hC); chk("nmr", 16'h1, 16'(n_mr)); chk("nfr", 16'h5, 16'(n_fr));
    cmd(4'h8); chk("halt", 16'h0, 16'(halt));
    close_out();
  end
endmodule : tb_serial_debug_command_unit
